/* gpol_map.svh */
/*
  Offsets, pad positions and reset values for the pad option latch block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef GPOL_MAP_SVH
`define GPOL_MAP_SVH

`define GPOL_PAD_COUNT 10
`define GPOL_XO_PAD 0
`define GPOL_REF_PAD 3
`define GPOL_CLKOUT_PAD_A 4
`define GPOL_DBG_DATA_PAD 4
`define GPOL_LED_PAD 5
`define GPOL_CLKOUT_PAD_B 6
`define GPOL_MATRIX_LO 1
`define GPOL_MATRIX_HI 3
`define GPOL_ROFF_LO 1
`define GPOL_ROFF_HI 2
`define GPOL_LATCH_RESET 1'h0
`define GPOL_SYNC_RESET 1'h1

`endif

/* gpol_pkg.sv */
/*
  Types shared by the pad option latch block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gpol_pkg;

  typedef enum logic [0:0] {
    STROBE_IDLE,
    STROBE_HIGH
  } gpol_strobe_t;

endpackage

/* gpol_opt_latch.sv */
/*
  Two-bit option latch that lives in the pad ring.
  Assumes its reset is the pad supply power-up, not the core reset,
  so the held options survive core shutdown and wake.
*/
`timescale 1ns/1ns
`include "gpol_map.svh"

module gpol_opt_latch
  import gpol_pkg::*;
(
  // Clock and pad power-up reset
  input wire logic clk,
  input wire logic padPorRst,
  // Load strobe and data
  input wire logic load,
  input wire logic dMatrix,
  input wire logic dRoff,
  // Held options
  output logic qMatrix,
  output logic qRoff
);

  // Core reset does not reach here: the options persist across shutdown
  always_ff @(posedge clk)
  begin
    if (padPorRst)
    begin
      qMatrix <= `GPOL_LATCH_RESET;
      qRoff <= `GPOL_LATCH_RESET;
    end
    else if (load)
    begin
      qMatrix <= dMatrix;
      qRoff <= dRoff;
    end
  end

endmodule // gpol_opt_latch

/* gpol_top.sv */
/*
  Pad special-role steering and the pad option latch control.
  Assumes the port-control bits, port data and debug signals come from
  logic on clk, and the pad inputs arrive from outside and need syncing.
*/
// Notes on behaviour
// - Pad 0 is input only; it may connect to crystal or programming supply.
// - Pad 3 can feed the frequency counter reference clock.
// - User clock out enabled separately on pad 4 and pad 6.
// - Pad 5 in application is only an LED current sink.
// - Pad 5 is debug clock in development; LED off during debug.
// - Pullup-disable option removes weak pullups on supporting pads.
// - Pullup-disable is held in pads and stays through shutdown.
// - In shutdown, any button pad outside the latched matrix pads 3 to 1 pulled low wakes the chip.
// - Latched matrix option pulls pads 3 to 1 low during shutdown.
// - Latched matrix disconnects pullups of pads 3 to 1, enables pulldowns.
// - Both options live in a 2-bit pad latch kept while unpowered.
// - Strobe 0 to 1 to 0 copies matrix and pullup-disable into latch.
// - Readback shows latched option values, not pending written ones.
// - Matrix affects pads 3 to 1; pullup-disable only pads 2 and 1.
`timescale 1ns/1ns
`include "gpol_map.svh"

module gpol_top
  import gpol_pkg::*;
#(
  parameter int PADS = `GPOL_PAD_COUNT
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic padPorRst,
  // Option control bits
  input wire logic portMatrix,
  input wire logic portRoff,
  input wire logic portStrobe,
  output logic latchedMatrix,
  output logic latchedRoff,
  // Special role controls
  input wire logic xoEnable,
  input wire logic nvmProgram,
  input wire logic refEnable,
  input wire logic clkEnable,
  input wire logic [1:0] clkOutSel,
  input wire logic userClk,
  output logic xoConnect,
  output logic vppConnect,
  output logic refClock,
  // General port
  input wire logic [PADS-1:0] port0_data_latch,
  input wire logic [PADS-1:0] port0_drive_config,
  output logic [PADS-1:0] padValue,
  // Debug adapter
  input wire logic debugActive,
  input wire logic debugDataOut,
  input wire logic debugDataOe,
  output logic debug_clock_pin,
  output logic debug_data_pin,
  // Power
  input wire logic shutdown,
  output logic wake,
  // Pads
  input wire logic [PADS-1:0] padIn,
  output logic [PADS-1:0] padOut,
  output logic [PADS-1:0] padOe,
  output logic [PADS-1:0] padPullUp,
  output logic [PADS-1:0] padPullDown,
  output logic ledSinkOn
);

  function automatic logic isButton(input int idx);
    isButton = (idx != `GPOL_LED_PAD);
  endfunction

  function automatic logic inRange(input int idx, input int lo, input int hi);
    inRange = (idx >= lo) && (idx <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchronisers
  logic [PADS-1:0] padMeta;
  logic [PADS-1:0] padSync;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      padMeta <= {PADS{`GPOL_SYNC_RESET}};
      padSync <= {PADS{`GPOL_SYNC_RESET}};
    end
    else
    begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencing and option latch
  gpol_strobe_t state;
  logic stageMatrix;
  logic stageRoff;
  logic loadPulse;

  // Load only once strobe has been seen high then low
  assign loadPulse = (state == STROBE_HIGH) && !portStrobe;

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= STROBE_IDLE;
    else
    begin
      case (state)
        STROBE_IDLE: if (portStrobe) state <= STROBE_HIGH;
        STROBE_HIGH: if (!portStrobe) state <= STROBE_IDLE;
        default: state <= STROBE_IDLE;
      endcase
    end
  end

  // Values follow the register only while strobe is high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stageMatrix <= `GPOL_LATCH_RESET;
      stageRoff <= `GPOL_LATCH_RESET;
    end
    else if (portStrobe)
    begin
      stageMatrix <= portMatrix;
      stageRoff <= portRoff;
    end
  end

  // Readback comes straight from the pad latch
  gpol_opt_latch u_latch (
    .clk(clk),
    .padPorRst(padPorRst),
    .load(loadPulse),
    .dMatrix(stageMatrix),
    .dRoff(stageRoff),
    .qMatrix(latchedMatrix),
    .qRoff(latchedRoff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pad drive and pulls
  logic [PADS-1:0] next_padOut;
  logic [PADS-1:0] next_padOe;
  logic [PADS-1:0] next_pullUp;
  logic [PADS-1:0] next_pullDown;
  logic clkOnA;
  logic clkOnB;

  // Debug data steals pad 4 over the clock output
  assign clkOnA = clkEnable && clkOutSel[0] && !debugActive;
  assign clkOnB = clkEnable && clkOutSel[1];

  genvar g;
  generate
    for (g = 0; g < PADS; g++)
    begin : g_pad
      always_comb
      begin
        next_padOut[g] = port0_data_latch[g];
        next_padOe[g] = port0_drive_config[g] | !port0_data_latch[g];
        if (g == `GPOL_XO_PAD)
          next_padOe[g] = 1'h0;
        else if (g == `GPOL_REF_PAD && refEnable)
          next_padOe[g] = 1'h0;
        else if (g == `GPOL_DBG_DATA_PAD && debugActive)
        begin
          next_padOut[g] = debugDataOut;
          next_padOe[g] = debugDataOe;
        end
        else if (g == `GPOL_CLKOUT_PAD_A && clkOnA)
        begin
          next_padOut[g] = userClk;
          next_padOe[g] = 1'h1;
        end
        else if (g == `GPOL_CLKOUT_PAD_B && clkOnB)
        begin
          next_padOut[g] = userClk;
          next_padOe[g] = 1'h1;
        end
        else if (g == `GPOL_LED_PAD)
        begin
          // Current sink only; the pad never drives high into the LED
          next_padOut[g] = 1'h0;
          next_padOe[g] = debugActive && !port0_data_latch[g];
        end
        // Matrix wins over pullup-disable on shared pads
        next_pullDown[g] = latchedMatrix
          && inRange(g, `GPOL_MATRIX_LO, `GPOL_MATRIX_HI);
        next_pullUp[g] = !next_pullDown[g]
          && !(latchedRoff && inRange(g, `GPOL_ROFF_LO, `GPOL_ROFF_HI));
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      padOut <= '1;
      padOe <= '0;
      padPullUp <= '1;
      padPullDown <= '0;
    end
    else
    begin
      padOut <= next_padOut;
      padOe <= next_padOe;
      padPullUp <= next_pullUp;
      padPullDown <= next_pullDown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special role outputs; matrix drivers sit pulled low, so they cannot wake
  logic [PADS-1:0] buttonMask;
  generate
    for (g = 0; g < PADS; g++)
    begin : g_mask
      assign buttonMask[g] = isButton(g) && !next_pullDown[g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ledSinkOn <= 1'h0;
      xoConnect <= 1'h0;
      vppConnect <= 1'h0;
      refClock <= 1'h0;
      debug_clock_pin <= 1'h0;
      debug_data_pin <= 1'h0;
      padValue <= '1;
      wake <= 1'h0;
    end
    else
    begin
      ledSinkOn <= port0_data_latch[`GPOL_LED_PAD] && !debugActive;
      vppConnect <= nvmProgram;
      xoConnect <= xoEnable && !nvmProgram;
      refClock <= refEnable && padSync[`GPOL_REF_PAD];
      debug_clock_pin <= padSync[`GPOL_LED_PAD];
      debug_data_pin <= padSync[`GPOL_DBG_DATA_PAD];
      padValue <= padSync;
      wake <= shutdown && |(~padSync & buttonMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_strobe_fall;
    portStrobe ##1 !portStrobe;
  endsequence
  sequence s_press;
    (shutdown && !padIn[`GPOL_XO_PAD])[*3];
  endsequence
  a_strobe_copy: assert property (s_strobe_fall |=>
    latchedMatrix == $past(portMatrix, 2) && latchedRoff == $past(portRoff, 2))
    else $error("strobe fall did not copy options");
  a_latch_hold: assert property (!loadPulse |=> $stable({latchedMatrix, latchedRoff}))
    else $error("latch changed without strobe fall");
  a_pad0_input: assert property (##1 !padOe[0])
    else $error("pad 0 driven");
  a_ref_input: assert property (refEnable |=> !padOe[3])
    else $error("ref pad driven");
  a_clkout_b: assert property (clkEnable && clkOutSel[1] |=>
    padOe[6] && padOut[6] == $past(userClk))
    else $error("clock not on pad 6");
  a_led_debug: assert property (debugActive |=> !ledSinkOn)
    else $error("LED on in debug");
  a_matrix_pulls: assert property (latchedMatrix |=>
    padPullDown[3:1] == 3'h7 && padPullUp[3:1] == 3'h0)
    else $error("matrix pulls wrong");
  a_roff_pulls: assert property (latchedRoff && !latchedMatrix |=>
    padPullUp[2:1] == 2'h0 && padPullUp[3] && !padPullDown[3])
    else $error("pullup-disable pulls wrong");
  a_wake_press: assert property (s_press |=> wake)
    else $error("no wake on press");
endmodule // gpol_top

/* gpol_pad_model.sv */
/*
  Behavioural pads and push buttons outside the pad option latch block.
  Assumes the block's pad drive, pull enables and a clock for idle noise.
*/
`timescale 1ns/1ns

module gpol_pad_model #(
  parameter int N = 10
)
(
  // Clock for floating-pad noise
  input wire logic clk,
  // Pad drive and pulls from the block
  input wire logic [N-1:0] padOut,
  input wire logic [N-1:0] padOe,
  input wire logic [N-1:0] padPullUp,
  input wire logic [N-1:0] padPullDown,
  // Buttons held to ground
  input wire logic [N-1:0] press,
  output logic [N-1:0] padIn
);
  logic [N-1:0] noise = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Undriven, unpulled pads wander so no stale level is trusted
  always_ff @(posedge clk)
  begin
    noise <= ~noise;
  end

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (press[i])
        padIn[i] = 1'b0;
      else if (padPullDown[i])
        padIn[i] = 1'b0;
      else if (padPullUp[i])
        padIn[i] = 1'b1;
      else
        padIn[i] = noise[i];
    end
  end
endmodule // gpol_pad_model

/* gpol_top_tb_top.sv */
/*
  Self-checking bench for the pad option latch block.
  Assumes the pad model file and the design files are compiled first.
*/
`timescale 1ns/1ns

module gpol_top_tb_top;
  import gpol_pkg::*;
  typedef struct {string name; int id; logic [9:0] exp;} gpol_note_t;
  logic clk, rst = 1, padPorRst = 1, portMatrix = 0, portRoff = 0, portStrobe = 0;
  logic xoEnable = 0, nvmProgram = 0, refEnable = 0, clkEnable = 0, userClk = 0;
  logic [1:0] clkOutSel = 0;
  logic debugActive = 0, shutdown = 0, latchedMatrix, latchedRoff, xoConnect, vppConnect;
  logic debugDataOut = 0, debugDataOe = 0;
  logic refClock, debug_clock_pin, debug_data_pin, wake, ledSinkOn;
  logic [9:0] data = 10'h3ff, press = 0, padValue, padIn, padOut, padOe, padPullUp, padPullDown;
  gpol_note_t notes[$];
  gpol_note_t n;
  event chk;
  int seed = 1126, error_cnt = 0, checked = 0, k;
  logic m, r;
  logic [2:0] p;
  logic [9:0] e;

  gpol_top #(.PADS(10)) u_dut (.clk(clk), .rst(rst), .padPorRst(padPorRst),
    .portMatrix(portMatrix), .portRoff(portRoff), .portStrobe(portStrobe),
    .latchedMatrix(latchedMatrix), .latchedRoff(latchedRoff), .xoEnable(xoEnable),
    .nvmProgram(nvmProgram), .refEnable(refEnable), .clkEnable(clkEnable),
    .clkOutSel(clkOutSel), .userClk(userClk), .xoConnect(xoConnect), .vppConnect(vppConnect),
    .refClock(refClock), .port0_data_latch(data), .port0_drive_config(10'h000),
    .padValue(padValue), .debugActive(debugActive), .debugDataOut(debugDataOut),
    .debugDataOe(debugDataOe),
    .debug_clock_pin(debug_clock_pin), .debug_data_pin(debug_data_pin), .shutdown(shutdown),
    .wake(wake), .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .ledSinkOn(ledSinkOn));

  gpol_pad_model #(.N(10)) u_pads (.clk(clk), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .press(press), .padIn(padIn));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  function automatic logic [9:0] obs(int id);
    case (id)
      0: obs = {8'h00, latchedMatrix, latchedRoff};
      1: obs = padPullUp;
      2: obs = padPullDown;
      3: obs = padOe;
      5: obs = padValue;
      6: obs = padOut;
      7: obs = {8'h00, debug_clock_pin, debug_data_pin};
      default: obs = {5'h00, ledSinkOn, xoConnect, vppConnect, refClock, wake};
    endcase
  endfunction

  task compare_val(string name, logic [9:0] exp, logic [9:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Notes are sampled on a falling edge, well clear of launches
  task note(string name, int id, logic [9:0] exp);
    notes.push_back('{name, id, exp});
    -> chk;
  endtask

  task settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task tally_and_finish();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Pending bits flip after the fall, so readback must not follow them
  task strobe(logic sm, logic sr);
    @(posedge clk);
    portMatrix <= sm;
    portRoff <= sr;
    @(posedge clk);
    portStrobe <= 1'b1;
    @(posedge clk);
    portStrobe <= 1'b0;
    @(posedge clk);
    portMatrix <= ~sm;
    portRoff <= ~sr;
    settle();
    note("latch", 0, {8'h00, sm, sr});
    e = 10'h3ff & ~(sm ? 10'h00e : 10'h000) & ~(sr ? 10'h006 : 10'h000);
    note("pullup", 1, e);
    note("pulldown", 2, sm ? 10'h00e : 10'h000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever
    begin
      @(chk);
      while (notes.size() > 0)
      begin
        n = notes.pop_front();
        compare_val(n.name, n.exp, obs(n.id));
      end
    end
  end

  initial
  begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    padPorRst <= 1'b0;
    settle();
    note("latch", 0, 10'h000);
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    for (k = 0; k < 6; k++)
    begin
      m = 1'($random(seed));
      r = 1'($random(seed));
      strobe(m, r);
    end
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    settle();
    note("latch", 0, {8'h00, m, r});
    strobe(1'b0, 1'b0);
    // One-cold scan of the matrix drivers, open drain
    for (k = 0; k < 4; k++)
    begin
      p = (k == 3) ? 3'h7 : ~(3'h1 << k);
      @(posedge clk);
      data[3:1] <= p;
      settle();
      note("oe", 3, {6'h00, ~p, 1'b0});
      note("value", 5, {6'h3f, p, 1'b1});
      note("out", 6, {4'hf, 1'b0, 1'b1, p, 1'b1});
    end
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      clkEnable <= 1'b1;
      clkOutSel <= k[1:0];
      userClk <= 1'($random(seed));
      xoEnable <= k[0];
      nvmProgram <= k[1];
      settle();
      note("oe", 3, {3'h0, k[1], 1'b0, k[0], 4'h0});
      note("misc", 4, {5'h00, 1'b1, k[0] & ~k[1], k[1], 2'h0});
    end
    // Adapter drives data high on pad 4 and holds its clock low on pad 5
    @(posedge clk);
    debugActive <= 1'b1;
    debugDataOut <= 1'b1;
    debugDataOe <= 1'b1;
    refEnable <= 1'b1;
    clkEnable <= 1'b0;
    press <= 10'h020;
    settle();
    note("misc", 4, 10'h006);
    note("oe", 3, 10'h010);
    note("value", 5, 10'h3df);
    note("out", 6, 10'h3df);
    note("debug", 7, 10'h001);
    @(posedge clk);
    debugActive <= 1'b0;
    debugDataOe <= 1'b0;
    press <= 10'h000;
    strobe(1'b1, 1'b0);
    // Matrix drivers pulled low in shutdown must not wake by themselves
    @(posedge clk);
    shutdown <= 1'b1;
    settle();
    note("misc", 4, 10'h014);
    @(posedge clk);
    press <= 10'h091;
    for (k = 0; k < 20 && wake !== 1'b1; k++)
      @(negedge clk);
    note("misc", 4, 10'h015);
    @(posedge clk);
    tally_and_finish();
  end
endmodule // gpol_top_tb_top
